// File: rtl/flmo_pkg.sv
// Shared constants and carrier types for the flash mode and RAM overlay block.
package flmo_pkg;

    localparam int unsigned ADDR_W        = 24;
    localparam int unsigned BLK_W         = 4;
    localparam int unsigned OVL_OFF_W     = 12;

    // Flash space layout: eight 4-kbyte blocks, one 32-kbyte block, three 64-kbyte blocks.
    localparam logic [ADDR_W-1:0] FLASH_BASE   = 24'h00_0000;
    localparam logic [ADDR_W-1:0] FLASH_END    = 24'h04_0000;
    localparam logic [ADDR_W-1:0] SMALL_END    = 24'h00_8000;
    localparam logic [ADDR_W-1:0] MID_END      = 24'h01_0000;
    localparam logic [BLK_W-1:0]  BLK_MID      = 4'h8;
    localparam logic [BLK_W-1:0]  BLK_LARGE0   = 4'h9;
    localparam logic [BLK_W-1:0]  BLK_LAST     = 4'hb;
    localparam logic [BLK_W-1:0]  BLK_NONE     = 4'hf;

    // Overlap RAM window that stands in for the selected small block.
    localparam logic [ADDR_W-1:0] OVL_RAM_BASE = 24'hff_e000;

    // Overlap control register layout; the upper nibble always reads as ones.
    localparam int unsigned       OVL_EN_BIT   = 3;
    localparam logic [7:0]        OVL_RESERVED = 8'hf0;
    localparam logic [3:0]        OVL_RESET    = 4'h0;

    // Mode pin codes.
    localparam logic [2:0] MD_BOOT_5  = 3'h1;
    localparam logic [2:0] MD_BOOT_7  = 3'h3;
    localparam logic [2:0] MD_UPROG_5 = 3'h5;
    localparam logic [2:0] MD_UPROG_7 = 3'h7;
    localparam logic [2:0] MD_NORMAL6 = 3'h6;

    // Pin sampling settles two cycles after reset release, capture on the third edge.
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    typedef enum logic [1:0] {
        MODE_USER  = 2'b00,
        MODE_UPROG = 2'b01,
        MODE_BOOT  = 2'b11,
        MODE_PROM  = 2'b10
    } flmo_mode_t;

    typedef enum logic [1:0] {
        OP_READ  = 2'b00,
        OP_PROG  = 2'b01,
        OP_ERASE = 2'b10
    } flmo_op_t;

    typedef struct packed {
        logic              valid;
        flmo_op_t          op;
        logic [ADDR_W-1:0] addr;
        logic [BLK_W-1:0]  blk;
    } flmo_req_t;

    typedef struct packed {
        logic              valid;
        logic              ram_sel;
        logic              flash_rd;
        logic              prog_ok;
        logic              erase_ok;
        logic              refused;
        logic [ADDR_W-1:0] addr;
        logic [BLK_W-1:0]  blk;
    } flmo_resp_t;

    // Maps a flash address to its erase block number.
    function automatic logic [BLK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
        logic [BLK_W-1:0] r;
        r = BLK_NONE;
        if (a < SMALL_END) begin
            r = {1'b0, a[14:12]};
        end else if (a < MID_END) begin
            r = BLK_MID;
        end else if (a < FLASH_END) begin
            r = BLK_LARGE0 + BLK_W'({2'b00, a[17:16]} - 4'h1);
        end
        return r;
    endfunction

endpackage

// File: rtl/flmo_ovl_dec.sv
// Address decoder that redirects reads of the selected small block into overlap RAM.
module flmo_ovl_dec (
    input  wire logic [flmo_pkg::ADDR_W-1:0] addr,
    input  wire logic                        overlap_enable,
    input  wire logic [2:0]                  overlap_select,
    output logic                             hit,
    output logic [flmo_pkg::ADDR_W-1:0]      ram_addr,
    output logic [flmo_pkg::BLK_W-1:0]       blk
);
    logic [flmo_pkg::BLK_W-1:0] sel_blk;

    assign blk      = flmo_pkg::blk_of(addr);
    // Codes 000 to 111 name small blocks one to eight, codes 101, 110, 111 the last three.
    assign sel_blk  = {1'b0, overlap_select};
    assign hit      = overlap_enable && (blk == sel_blk);
    // Same offset inside the 4-kbyte window, no extra wait.
    assign ram_addr = flmo_pkg::OVL_RAM_BASE | {12'h000, addr[flmo_pkg::OVL_OFF_W-1:0]};
endmodule

// File: rtl/flmo_ctrl.sv
// Flash operating-mode selection, program/erase protection and RAM overlay routing.
//
// Contract
// - With overlay on, codes 101, 110, 111 select small blocks six to eight.
// - Overlay off overlays nothing; on overlays the selected block and protects all.
// - Mode comes from mode pins, write-enable pin and PROM pin sampled on the third edge after reset release.
// - User mode allows flash reads and blocks every program or erase.
// - Program and erase only in boot, user program and PROM modes.
// - Mode 6 offers neither boot mode nor user program mode.
// - Write-enable pin edges switch between user and user program mode when the captured mode pins hold a user program code.
// - Boot mode erases the whole flash array to all ones first.
// - Boot mode loads host program serially and copies erase routine into RAM.
// - Erase works only on whole blocks, never single bytes.
// - Reads of the selected emulation block return overlap RAM data.
// - Clearing overlay enable sends later accesses back to real flash.
// - Flash holds three 64k, one 32k and eight 4k erasable blocks.
module flmo_ctrl (
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire logic [2:0]            mode_pins,
    input  wire logic                  flash_write_enable_pin,
    input  wire logic                  prom_mode_pin,
    input  wire logic                  onchip_ram_enable,
    input  wire logic                  ovl_wr,
    input  wire logic [3:0]            ovl_wdata,
    input  wire flmo_pkg::flmo_req_t   req,
    output flmo_pkg::flmo_resp_t       resp,
    output flmo_pkg::flmo_mode_t       mode,
    output logic [7:0]                 overlap_control_register,
    output logic                       overlay_active,
    output logic                       boot_erase_all,
    output logic                       boot_copy_routine,
    output logic                       boot_loader_run
);
    // Pin synchronisers.
    logic [2:0]                 md_meta;
    logic [2:0]                 md_sync;
    logic                       fwe_meta;
    logic                       fwe_sync;
    logic                       fwe_prev;
    logic                       prom_meta;
    logic                       prom_sync;

    logic [1:0]                 strap_cnt;
    logic                       started;
    logic [2:0]                 md_cap;
    logic [3:0]                 ovl_reg;
    flmo_pkg::flmo_mode_t       next_mode;

    wire                        capture    = !started && (strap_cnt == flmo_pkg::STRAP_WAIT);
    wire                        fwe_rise   = started && fwe_sync && !fwe_prev;
    wire                        fwe_fall   = started && !fwe_sync && fwe_prev;
    wire                        md_is_6    = (md_sync == flmo_pkg::MD_NORMAL6);
    wire                        md_boot    = (md_sync == flmo_pkg::MD_BOOT_5) || (md_sync == flmo_pkg::MD_BOOT_7);
    wire                        md_uprog   = (md_sync == flmo_pkg::MD_UPROG_5) || (md_sync == flmo_pkg::MD_UPROG_7);
    wire                        cap_uprog  = (md_cap == flmo_pkg::MD_UPROG_5) || (md_cap == flmo_pkg::MD_UPROG_7);
    wire                        ovl_en     = ovl_reg[flmo_pkg::OVL_EN_BIT];
    wire                        pe_mode    = (mode == flmo_pkg::MODE_BOOT) || (mode == flmo_pkg::MODE_UPROG)
                                             || (mode == flmo_pkg::MODE_PROM);
    // Overlay on protects every block, so emulation never corrupts real flash.
    wire                        pe_allowed = started && pe_mode && !ovl_en;
    wire                        dec_hit;
    wire [flmo_pkg::ADDR_W-1:0] dec_ram_addr;
    wire [flmo_pkg::BLK_W-1:0]  dec_blk;
    wire                        in_flash   = (req.addr < flmo_pkg::FLASH_END);
    wire                        is_read    = req.op == flmo_pkg::OP_READ;
    wire                        is_prog    = req.op == flmo_pkg::OP_PROG;
    wire                        is_erase   = req.op == flmo_pkg::OP_ERASE;
    // Erase names a whole block number only; there is no byte-level erase path.
    wire                        blk_legal  = req.blk <= flmo_pkg::BLK_LAST;
    wire                        rd_ok      = is_read && in_flash;
    wire                        prog_ok    = is_prog && in_flash && pe_allowed;
    wire                        erase_ok   = is_erase && blk_legal && pe_allowed;
    flmo_pkg::flmo_resp_t       next_resp;

    flmo_ovl_dec u_dec (
        .addr           (req.addr),
        .overlap_enable (ovl_en),
        .overlap_select (ovl_reg[2:0]),
        .hit            (dec_hit),
        .ram_addr       (dec_ram_addr),
        .blk            (dec_blk)
    );

    always_comb begin
        next_mode = mode;
        if (capture) begin
            // Mode 6 strap never yields boot or user program mode.
            if (prom_sync) begin
                next_mode = flmo_pkg::MODE_PROM;
            end else if (fwe_sync && md_boot && !md_is_6) begin
                next_mode = flmo_pkg::MODE_BOOT;
            end else if (fwe_sync && md_uprog && !md_is_6) begin
                next_mode = flmo_pkg::MODE_UPROG;
            end else begin
                next_mode = flmo_pkg::MODE_USER;
            end
        end else begin
            case (mode)
                flmo_pkg::MODE_USER: begin
                    if (fwe_rise && cap_uprog) begin
                        next_mode = flmo_pkg::MODE_UPROG;
                    end
                end
                flmo_pkg::MODE_UPROG: begin
                    if (fwe_fall) begin
                        next_mode = flmo_pkg::MODE_USER;
                    end
                end
                // Boot mode is left only through reset.
                flmo_pkg::MODE_BOOT: next_mode = flmo_pkg::MODE_BOOT;
                flmo_pkg::MODE_PROM: next_mode = flmo_pkg::MODE_PROM;
                default:             next_mode = flmo_pkg::MODE_USER;
            endcase
        end
    end

    always_comb begin
        next_resp          = '0;
        next_resp.valid    = req.valid;
        next_resp.blk      = is_erase ? req.blk : dec_blk;
        next_resp.addr     = req.addr;
        if (req.valid) begin
            if (rd_ok && dec_hit) begin
                next_resp.ram_sel = 1'b1;
                next_resp.addr    = dec_ram_addr;
            end else begin
                next_resp.flash_rd = rd_ok;
            end
            next_resp.prog_ok  = prog_ok;
            next_resp.erase_ok = erase_ok;
            next_resp.refused  = !(rd_ok || prog_ok || erase_ok);
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            md_meta   <= 3'h0;
            md_sync   <= 3'h0;
            fwe_meta  <= 1'b0;
            fwe_sync  <= 1'b0;
            prom_meta <= 1'b0;
            prom_sync <= 1'b0;
        end else begin
            md_meta   <= mode_pins;
            md_sync   <= md_meta;
            fwe_meta  <= flash_write_enable_pin;
            fwe_sync  <= fwe_meta;
            prom_meta <= prom_mode_pin;
            prom_sync <= prom_meta;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            strap_cnt <= 2'h0;
            started   <= 1'b0;
            md_cap    <= 3'h0;
            fwe_prev  <= 1'b0;
            mode      <= flmo_pkg::MODE_USER;
        end else begin
            if (!started && !capture) begin
                strap_cnt <= strap_cnt + 2'h1;
            end
            if (capture) begin
                started <= 1'b1;
                md_cap  <= md_sync;
            end
            fwe_prev <= fwe_sync;
            mode     <= next_mode;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ovl_reg <= flmo_pkg::OVL_RESET;
        end else if (ovl_wr) begin
            ovl_reg <= ovl_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            overlap_control_register <= flmo_pkg::OVL_RESERVED;
            overlay_active           <= 1'b0;
            boot_erase_all           <= 1'b0;
            boot_copy_routine        <= 1'b0;
            boot_loader_run          <= 1'b0;
            resp                     <= '0;
        end else begin
            overlap_control_register <= flmo_pkg::OVL_RESERVED | {4'h0, ovl_reg};
            overlay_active           <= ovl_en;
            // Entry to boot mode fires the full erase and the routine copy once.
            boot_erase_all           <= capture && (next_mode == flmo_pkg::MODE_BOOT);
            boot_copy_routine        <= capture && (next_mode == flmo_pkg::MODE_BOOT);
            boot_loader_run          <= next_mode == flmo_pkg::MODE_BOOT;
            resp                     <= next_resp;
        end
    end

    default clocking dc @(posedge core_clk); endclocking
    default disable iff (reset);

    a_overlay_read_hit: assert property (
        (req.valid && is_read && ovl_en && in_flash && (flmo_pkg::blk_of(req.addr) == {1'b0, ovl_reg[2:0]}))
        |=> resp.ram_sel && !resp.flash_rd)
        else $error("Read of selected block not routed to overlap RAM.");
    a_overlay_off_flash: assert property (
        (req.valid && is_read && in_flash && !ovl_en) |=> resp.flash_rd && !resp.ram_sel)
        else $error("Read with overlay off did not reach flash.");
    a_user_no_pe: assert property (
        (mode == flmo_pkg::MODE_USER) && req.valid && !is_read |=> resp.refused && !resp.prog_ok && !resp.erase_ok)
        else $error("Program or erase granted in user mode.");
    a_overlay_protects: assert property (
        ovl_en && req.valid |=> !resp.prog_ok && !resp.erase_ok)
        else $error("Program or erase granted while overlay enabled.");
    a_pe_mode_grant: assert property (
        started && req.valid && is_prog && in_flash && !ovl_en && (mode == flmo_pkg::MODE_UPROG) |=> resp.prog_ok)
        else $error("Program refused in user program mode.");
    a_mode6_no_boot: assert property (
        capture && md_is_6 && !prom_sync |=> mode == flmo_pkg::MODE_USER)
        else $error("Mode 6 strap produced a programming mode.");
    a_fwe_switch: assert property (
        (mode == flmo_pkg::MODE_UPROG) && fwe_fall |=> mode == flmo_pkg::MODE_USER)
        else $error("Write-enable fall did not leave user program mode.");
    a_boot_erase_once: assert property (
        $rose(boot_loader_run) |-> boot_erase_all && boot_copy_routine ##1 !boot_erase_all[*3])
        else $error("Boot entry did not erase exactly once.");
    a_ram_offset: assert property (
        resp.ram_sel |-> resp.addr[flmo_pkg::OVL_OFF_W-1:0] == $past(req.addr[flmo_pkg::OVL_OFF_W-1:0]))
        else $error("Overlap RAM offset does not match flash offset.");
    a_erase_block_only: assert property (
        req.valid && is_erase && !blk_legal |=> resp.refused)
        else $error("Erase of an invalid block number was granted.");

    c_overlay_read: cover property (req.valid && is_read && dec_hit ##1 resp.ram_sel);
    c_boot_entry:   cover property ($rose(boot_loader_run));
    c_uprog_switch: cover property ((mode == flmo_pkg::MODE_USER) ##1 (mode == flmo_pkg::MODE_UPROG));
    c_erase_grant:  cover property (resp.erase_ok);
endmodule

// File: test/flmo_core_model.sv
// Behavioural processor core that issues flash and RAM accesses and overlay register writes.
module flmo_core_model (
    input  wire logic                 core_clk,
    input  wire flmo_pkg::flmo_resp_t resp,
    output flmo_pkg::flmo_req_t       req,
    output logic                      ovl_wr,
    output logic [3:0]                ovl_wdata,
    output logic                      onchip_ram_enable
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        req = '0;
        ovl_wr = 1'b0;
        ovl_wdata = 4'h0;
        onchip_ram_enable = 1'b0;
    end

    // Accesses name flash addresses and the first address past flash only, so the overlap RAM window is never loaded from here.
    // Released address and block fields carry the inverse of the last value, so a stale address never looks current.
    task automatic access(input flmo_pkg::flmo_op_t op, input logic [23:0] addr, input logic [3:0] blk,
                          output flmo_pkg::flmo_resp_t r);
        @(posedge core_clk);
        #1;
        req.valid = 1'b1;
        req.op = op;
        req.addr = addr;
        req.blk = blk;
        @(posedge core_clk);
        #1;
        // The registered answer stands only for the cycle after the taking edge.
        r = resp;
        req.valid = 1'b0;
        req.addr = ~addr;
        req.blk = ~blk;
    endtask

    task automatic write_ovl(input logic [3:0] v);
        @(posedge core_clk);
        #1;
        if (v[3]) begin
            onchip_ram_enable = 1'b1;
        end
        ovl_wr = 1'b1;
        ovl_wdata = v;
        @(posedge core_clk);
        #1;
        ovl_wr = 1'b0;
        ovl_wdata = ~v;
        @(posedge core_clk);
        #1;
    endtask
endmodule

// File: test/flmo_ctrl_bench.sv
// Self-checking bench for the flash mode and RAM overlay controller.
module flmo_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [5:0] F_RD = 6'b10_1000;
    localparam logic [5:0] F_RAM = 6'b11_0000;
    localparam logic [5:0] F_PROG = 6'b10_0100;
    localparam logic [5:0] F_ERASE = 6'b10_0010;
    localparam logic [5:0] F_REF = 6'b10_0001;

    logic                 core_clk = 1'b0;
    logic                 reset = 1'b1;
    logic [2:0]           mode_pins = 3'h6;
    logic                 flash_write_enable_pin = 1'b0;
    logic                 prom_mode_pin = 1'b0;
    logic                 onchip_ram_enable;
    logic                 ovl_wr;
    logic [3:0]           ovl_wdata;
    flmo_pkg::flmo_req_t  req;
    flmo_pkg::flmo_resp_t resp;
    flmo_pkg::flmo_resp_t r;
    flmo_pkg::flmo_mode_t mode;
    logic [7:0]           overlap_control_register;
    logic                 overlay_active;
    logic                 boot_erase_all;
    logic                 boot_copy_routine;
    logic                 boot_loader_run;
    int                   errors = 0;
    int                   check_count = 0;

    always #25 core_clk = ~core_clk;

    flmo_ctrl flmo_ctrl_i (.core_clk(core_clk), .reset(reset), .mode_pins(mode_pins),
        .flash_write_enable_pin(flash_write_enable_pin), .prom_mode_pin(prom_mode_pin),
        .onchip_ram_enable(onchip_ram_enable), .ovl_wr(ovl_wr), .ovl_wdata(ovl_wdata), .req(req),
        .resp(resp), .mode(mode), .overlap_control_register(overlap_control_register),
        .overlay_active(overlay_active), .boot_erase_all(boot_erase_all),
        .boot_copy_routine(boot_copy_routine), .boot_loader_run(boot_loader_run));

    flmo_core_model flmo_core_model_i (.core_clk(core_clk), .resp(resp), .req(req), .ovl_wr(ovl_wr),
        .ovl_wdata(ovl_wdata), .onchip_ram_enable(onchip_ram_enable));

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input flmo_pkg::flmo_resp_t x, input logic [5:0] exp);
        chk_val(32'({x.valid, x.ram_sel, x.flash_rd, x.prog_ok, x.erase_ok, x.refused}), 32'(exp));
    endtask

    // Pins are held steady through reset and up to the capture edge, the third after release, as the strap sampler needs.
    task automatic restart(input logic [2:0] md, input logic fw, input logic pr);
        @(posedge core_clk);
        #1;
        reset = 1'b1;
        mode_pins = md;
        flash_write_enable_pin = fw;
        prom_mode_pin = pr;
        repeat (2) @(posedge core_clk);
        #1;
        reset = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic wait_mode(input flmo_pkg::flmo_mode_t exp);
        for (int i = 0; i < 10 && mode !== exp; i++) begin
            @(posedge core_clk);
            #1;
        end
        chk_val(32'(mode), 32'(exp));
    endtask

    task automatic t_user;
        // Overlay bits stay clear throughout, since this test never writes the overlap control register.
        restart(flmo_pkg::MD_NORMAL6, 1'b1, 1'b0);
        chk_val(32'(mode), 32'(flmo_pkg::MODE_USER));
        restart(flmo_pkg::MD_UPROG_5, 1'b0, 1'b0);
        chk_val(32'(mode), 32'(flmo_pkg::MODE_USER));
        flmo_core_model_i.access(flmo_pkg::OP_READ, 24'h01_2345, 4'h0, r);
        chk_resp(r, F_RD);
        flmo_core_model_i.access(flmo_pkg::OP_PROG, 24'h01_2345, 4'h0, r);
        chk_resp(r, F_REF);
        flmo_core_model_i.access(flmo_pkg::OP_ERASE, 24'h00_0000, 4'h2, r);
        chk_resp(r, F_REF);
        flmo_core_model_i.access(flmo_pkg::OP_READ, 24'h04_0000, 4'h0, r);
        chk_resp(r, F_REF);
    endtask

    task automatic t_boot;
        for (int i = 0; i < 2; i++) begin
            restart(i == 0 ? flmo_pkg::MD_BOOT_5 : flmo_pkg::MD_BOOT_7, 1'b1, 1'b0);
            chk_val(32'(mode), 32'(flmo_pkg::MODE_BOOT));
            chk_val(32'({boot_erase_all, boot_loader_run}), 32'h0000_0003);
            chk_val(32'(boot_copy_routine), 32'h0000_0001);
            @(posedge core_clk);
            #1;
            chk_val(32'({boot_erase_all, boot_copy_routine}), 32'h0000_0000);
            flmo_core_model_i.access(flmo_pkg::OP_ERASE, 24'h03_0000, 4'hb, r);
            chk_resp(r, F_ERASE);
            flmo_core_model_i.access(flmo_pkg::OP_PROG, 24'h00_0010, 4'h0, r);
            chk_resp(r, F_PROG);
        end
    endtask

    task automatic t_uprog;
        logic [23:0] a [4] = '{24'h00_7fff, 24'h00_8000, 24'h01_0000, 24'h03_ffff};
        logic [3:0]  b [4] = '{4'h7, 4'h8, 4'h9, 4'hb};
        restart(flmo_pkg::MD_UPROG_7, 1'b1, 1'b0);
        chk_val(32'({mode, boot_loader_run}), 32'({flmo_pkg::MODE_UPROG, 1'b0}));
        flmo_core_model_i.access(flmo_pkg::OP_ERASE, 24'h00_3000, 4'h3, r);
        chk_resp(r, F_ERASE);
        chk_val(32'(r.blk), 32'h0000_0003);
        flmo_core_model_i.access(flmo_pkg::OP_PROG, 24'h00_3010, 4'h0, r);
        chk_resp(r, F_PROG);
        flmo_core_model_i.access(flmo_pkg::OP_ERASE, 24'h00_0000, 4'hc, r);
        chk_resp(r, F_REF);
        for (int i = 0; i < 4; i++) begin
            flmo_core_model_i.access(flmo_pkg::OP_READ, a[i], 4'h0, r);
            chk_val(32'(r.blk), 32'(b[i]));
        end
    endtask

    task automatic t_prom;
        restart(flmo_pkg::MD_NORMAL6, 1'b0, 1'b1);
        chk_val(32'(mode), 32'(flmo_pkg::MODE_PROM));
        flmo_core_model_i.access(flmo_pkg::OP_PROG, 24'h02_0000, 4'h0, r);
        chk_resp(r, F_PROG);
    endtask

    task automatic t_fwe;
        restart(flmo_pkg::MD_UPROG_5, 1'b1, 1'b0);
        // Flash control register 1 is taken as clear and settled before each pin change.
        flash_write_enable_pin = 1'b0;
        wait_mode(flmo_pkg::MODE_USER);
        flmo_core_model_i.access(flmo_pkg::OP_PROG, 24'h00_0020, 4'h0, r);
        chk_resp(r, F_REF);
        flash_write_enable_pin = 1'b1;
        wait_mode(flmo_pkg::MODE_UPROG);
    endtask

    task automatic t_overlay;
        logic [23:0] a;
        restart(flmo_pkg::MD_UPROG_7, 1'b1, 1'b0);
        for (int c = 5; c < 8; c++) begin
            a = {9'h000, 3'(c), 12'h5a5};
            flmo_core_model_i.write_ovl({1'b1, 3'(c)});
            chk_val(32'({overlap_control_register, overlay_active}), 32'({4'hf, 1'b1, 3'(c), 1'b1}));
            flmo_core_model_i.access(flmo_pkg::OP_READ, a, 4'h0, r);
            chk_resp(r, F_RAM);
            chk_val(32'({r.addr, r.blk}), 32'({12'hffe, 12'h5a5, 1'b0, 3'(c)}));
            flmo_core_model_i.access(flmo_pkg::OP_READ, a - 24'h00_1000, 4'h0, r);
            chk_resp(r, F_RD);
            flmo_core_model_i.access(flmo_pkg::OP_ERASE, 24'h03_0000, 4'hb, r);
            chk_resp(r, F_REF);
            flmo_core_model_i.write_ovl({1'b0, 3'(c)});
            chk_val(32'(overlay_active), 32'h0000_0000);
            flmo_core_model_i.access(flmo_pkg::OP_READ, a, 4'h0, r);
            chk_resp(r, F_RD);
            flmo_core_model_i.access(flmo_pkg::OP_ERASE, 24'h03_0000, 4'hb, r);
            chk_resp(r, F_ERASE);
        end
    endtask

    task automatic finish_test;
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // The run needs about 140 cycles; the 4000-cycle limit leaves a wide margin.
    initial begin
        #200000;
        errors++;
        finish_test();
    end

    initial begin
        t_user();
        t_boot();
        t_uprog();
        t_prom();
        t_fwe();
        t_overlay();
        finish_test();
    end
endmodule
